// ==== fcq_fifo.sv ====
// configurable native queue: storage, flags, handshake, counts, register port, interrupt
// assumes one clock; write and read sides are both on clk
`include "fcq_consts.svh"

module fcq_fifo
  import fcq_pkg::*;
#(
  parameter fcq_mem_e MEM_TYPE   = FCQ_MEM_BRAM,
  parameter bit       INDEP_CLK  = 1'b0,
  parameter bit       OUT_REG    = 1'b0,
  parameter bit       ECC_EN     = 1'b0,
  parameter bit       SYNC_RST   = 1'b0,
  parameter int       WR_W       = 8,
  parameter int       RD_W       = 8,
  parameter int       DEPTH      = 512,
  parameter int       NEAR_GAP   = 16,
  parameter int       DOUT_RST   = 0
) (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            srst,
  input  wire logic            wr_en,
  input  wire logic [WR_W-1:0] wr_data,
  input  wire logic            inj_sbit,
  input  wire logic            inj_dbit,
  input  wire logic            rd_en,
  output logic [((INDEP_CLK && MEM_TYPE == FCQ_MEM_BRAM) ? RD_W : WR_W)-1:0] rd_data,
  output logic                 rd_valid,
  output logic                 sbit_err,
  output logic                 dbit_err,
  output logic                 full,
  output logic                 empty,
  output logic                 almost_full,
  output logic                 almost_empty,
  output logic                 prog_full,
  output logic                 prog_empty,
  output logic                 wr_ack,
  output logic                 overflow,
  output logic                 underflow,
  output logic [15:0]          data_count,
  output logic [15:0]          wr_count,
  output logic [15:0]          rd_count,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [31:0]          reg_rdata,
  output logic                 irq
);

  // ==========================================
  // configuration
  localparam bit CONV_OK = INDEP_CLK && (MEM_TYPE == FCQ_MEM_BRAM); // R03
  localparam int RD_EW   = CONV_OK ? RD_W : WR_W;
  localparam int UNIT_W  = (WR_W < RD_EW) ? WR_W : RD_EW; // R02
  localparam int WRU     = WR_W / UNIT_W;
  localparam int RDU     = RD_EW / UNIT_W;
  localparam int AW      = $clog2(DEPTH);
  localparam int CW      = AW + 1;
  localparam bit IS_MACRO = (MEM_TYPE == FCQ_MEM_MACRO);
  localparam bit USE_PIPE = OUT_REG && ((MEM_TYPE == FCQ_MEM_BRAM) || (IS_MACRO && !INDEP_CLK)); // R06
  localparam bit ECC_OK  = ECC_EN && ((MEM_TYPE == FCQ_MEM_BRAM) || IS_MACRO); // R07
  localparam bit SYNC_OK = SYNC_RST && !INDEP_CLK
                           && ((MEM_TYPE == FCQ_MEM_BRAM) || (MEM_TYPE == FCQ_MEM_DRAM)); // R16
  // only the shared-clock macro honours a custom reset word; others clear to zero
  localparam logic [RD_EW-1:0] RST_WORD = (IS_MACRO && !INDEP_CLK) ? RD_EW'(DOUT_RST) : '0; // R05
  localparam logic [CW-1:0] WRU_C  = CW'(WRU);
  localparam logic [CW-1:0] RDU_C  = CW'(RDU);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] GAP_C  = CW'(NEAR_GAP);
  localparam int PIPE_LAT = USE_PIPE ? 2 : 1;

  // ==========================================
  // storage
  logic [UNIT_W-1:0] mem_reg [DEPTH];
  logic              sflag_reg [DEPTH];
  logic              dflag_reg [DEPTH];

  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0]    count_reg, count_next;
  logic [RD_EW-1:0] dout_reg, dout_next;
  logic             valid_reg, valid_next;
  logic             dsb_reg, dsb_next;
  logic             ddb_reg, ddb_next;
  logic [RD_EW-1:0] pdout_reg, pdout_next;
  logic             pvalid_reg, pvalid_next;
  logic             psb_reg, psb_next;
  logic             pdb_reg, pdb_next;
  logic             ack_reg, ack_next;
  logic             ovf_reg, ovf_next;
  logic             udf_reg, udf_next;

  logic             look_reg, look_next;
  logic [15:0]      pf_thr_reg, pf_thr_next;
  logic [15:0]      pe_thr_reg, pe_thr_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic [`FCQ_EV_W-1:0] ist_reg, ist_next;
  logic [`FCQ_EV_W-1:0] ien_reg, ien_next;

  logic [CW-1:0]    free;
  logic [CW-1:0]    avail;
  logic             push;
  logic             pop;
  logic             flush;
  logic             macro_near_full;
  logic             macro_near_empty;
  logic [RD_EW-1:0] head_word;
  logic             head_sb;
  logic             head_db;
  logic [`FCQ_EV_W-1:0] ev;

  // assemble a read word from consecutive units, lowest unit in the low bits
  function automatic logic [RD_EW+1:0] word_at(input logic [AW-1:0] ptr);
    logic [RD_EW-1:0] w;
    logic             sb;
    logic             db;
    logic [AW-1:0]    a;
    w  = '0;
    sb = 1'b0;
    db = 1'b0;
    for (int i = 0; i < RDU; i++) begin
      a = ptr + AW'(i);
      w[i*UNIT_W +: UNIT_W] = mem_reg[a];
      sb = sb | sflag_reg[a];
      db = db | dflag_reg[a];
    end
    // a double error cannot be corrected, so the word leaves damaged
    if (db) begin
      w[0] = ~w[0];
    end
    return {db, sb && !db, w}; // R07
  endfunction

  // ==========================================
  // queue core
  assign free  = DEPTH_C - count_reg;
  assign flush = (SYNC_OK && srst) || (reg_wr && reg_addr == `FCQ_OFS_CTRL
                                       && reg_wdata[`FCQ_CTRL_FLUSH]); // R16
  assign push  = wr_en && (free >= WRU_C); // R17
  assign pop   = look_reg ? (rd_en && valid_reg) : (rd_en && count_reg >= RDU_C); // R17

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + AW'(WRU);
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + AW'(RDU); // R18
    end
    count_next = count_reg + (push ? WRU_C : '0) - (pop ? RDU_C : '0);
    if (flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next  = '0;
    end
  end

  // words written this cycle are not in mem_reg yet, so they show a cycle later
  assign avail = count_reg - (pop ? RDU_C : '0);
  assign {head_db, head_sb, head_word} = word_at(look_reg ? rd_ptr_next : rd_ptr_reg);

  always_comb begin
    dout_next   = dout_reg;
    valid_next  = 1'b0;
    dsb_next    = 1'b0;
    ddb_next    = 1'b0;
    ack_next    = push; // R12
    ovf_next    = wr_en && !push; // R17
    udf_next    = rd_en && !pop; // R17
    if (look_reg) begin
      valid_next = (avail >= RDU_C); // R01
      if (valid_next) begin
        dout_next = head_word; // R01
        dsb_next  = head_sb && ECC_OK;
        ddb_next  = head_db && ECC_OK;
      end
    end else if (pop) begin
      dout_next  = head_word;
      valid_next = 1'b1;
      dsb_next   = head_sb && ECC_OK;
      ddb_next   = head_db && ECC_OK;
    end
    if (flush) begin
      dout_next  = RST_WORD; // R05
      valid_next = 1'b0;
    end
    pdout_next  = flush ? RST_WORD : dout_reg; // R04
    pvalid_next = valid_reg && !flush; // R04
    psb_next    = dsb_reg;
    pdb_next    = ddb_reg;
  end

  always_ff @(posedge clk) begin // R15
    if (push) begin
      for (int i = 0; i < WRU; i++) begin
        mem_reg[wr_ptr_reg + AW'(i)]   <= wr_data[i*UNIT_W +: UNIT_W];
        sflag_reg[wr_ptr_reg + AW'(i)] <= ECC_OK && inj_sbit && (i == 0); // R07
        dflag_reg[wr_ptr_reg + AW'(i)] <= ECC_OK && inj_dbit && (i == 0); // R07
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      dout_reg   <= RST_WORD; // R05
      valid_reg  <= 1'b0;
      dsb_reg    <= 1'b0;
      ddb_reg    <= 1'b0;
      pdout_reg  <= RST_WORD;
      pvalid_reg <= 1'b0;
      psb_reg    <= 1'b0;
      pdb_reg    <= 1'b0;
      ack_reg    <= 1'b0;
      ovf_reg    <= 1'b0;
      udf_reg    <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      dout_reg   <= dout_next;
      valid_reg  <= valid_next;
      dsb_reg    <= dsb_next;
      ddb_reg    <= ddb_next;
      pdout_reg  <= pdout_next;
      pvalid_reg <= pvalid_next;
      psb_reg    <= psb_next;
      pdb_reg    <= pdb_next;
      ack_reg    <= ack_next;
      ovf_reg    <= ovf_next;
      udf_reg    <= udf_next;
    end
  end

  // ==========================================
  // outputs and flags
  // look-ahead keeps the direct path: a delayed valid would break the pop handshake
  assign rd_data  = (USE_PIPE && !look_reg) ? pdout_reg : dout_reg; // R04
  assign rd_valid = (USE_PIPE && !look_reg) ? pvalid_reg : valid_reg; // R12
  assign sbit_err = (USE_PIPE && !look_reg) ? psb_reg : dsb_reg; // R07
  assign dbit_err = (USE_PIPE && !look_reg) ? pdb_reg : ddb_reg; // R07
  assign wr_ack    = ack_reg; // R12
  assign overflow  = ovf_reg; // R12
  assign underflow = udf_reg; // R12

  assign full  = (free < WRU_C); // R08
  assign empty = look_reg ? !valid_reg : (count_reg < RDU_C); // R08
  assign almost_full  = !IS_MACRO && (free < (WRU_C << 1)); // R10
  assign almost_empty = !IS_MACRO && (count_reg < (RDU_C << 1)); // R10
  assign macro_near_full  = IS_MACRO && (free <= GAP_C);
  assign macro_near_empty = IS_MACRO && (count_reg <= GAP_C);
  assign prog_full  = IS_MACRO ? macro_near_full
                               : (16'(count_reg) >= pf_thr_reg); // R09 R11
  assign prog_empty = IS_MACRO ? macro_near_empty
                               : (16'(count_reg) <= pe_thr_reg); // R09 R11

  // counts in storage units, write words and read words; one clock, one view
  assign data_count = 16'(count_reg); // R13
  assign wr_count   = 16'(count_reg / WRU_C); // R14
  assign rd_count   = 16'(count_reg / RDU_C); // R14

  // ==========================================
  // register port and interrupt
  assign ev = {dbit_err, sbit_err, udf_reg, ovf_reg};

  always_comb begin
    look_next   = look_reg;
    pf_thr_next = pf_thr_reg;
    pe_thr_next = pe_thr_reg;
    ien_next    = ien_reg;
    ist_next    = ist_reg;
    rdata_next  = '0;
    if (reg_wr) begin
      case (reg_addr)
        `FCQ_OFS_CTRL:       look_next   = reg_wdata[`FCQ_CTRL_LOOK];
        `FCQ_OFS_PFULL_THR:  pf_thr_next = reg_wdata[15:0];
        `FCQ_OFS_PEMPTY_THR: pe_thr_next = reg_wdata[15:0];
        `FCQ_OFS_IRQ_EN:     ien_next    = reg_wdata[`FCQ_EV_W-1:0];
        `FCQ_OFS_IRQ_CLR:    ist_next    = ist_reg & ~reg_wdata[`FCQ_EV_W-1:0];
        default:             ;
      endcase
    end
    // a new event beats a clear in the same cycle
    ist_next = ist_next | ev;
    if (reg_rd) begin
      case (reg_addr)
        `FCQ_OFS_CTRL:       rdata_next = {31'h0, look_reg};
        `FCQ_OFS_PFULL_THR:  rdata_next = {16'h0, pf_thr_reg};
        `FCQ_OFS_PEMPTY_THR: rdata_next = {16'h0, pe_thr_reg};
        `FCQ_OFS_STATUS:     rdata_next = {26'h0, prog_empty, prog_full, almost_empty,
                                           almost_full, empty, full};
        `FCQ_OFS_COUNT:      rdata_next = {16'h0, data_count};
        `FCQ_OFS_IRQ_STAT:   rdata_next = {28'h0, ist_reg};
        `FCQ_OFS_IRQ_EN:     rdata_next = {28'h0, ien_reg};
        default:             rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      look_reg   <= `FCQ_RST_CTRL;
      pf_thr_reg <= `FCQ_RST_PFULL_THR;
      pe_thr_reg <= `FCQ_RST_PEMPTY_THR;
      ien_reg    <= `FCQ_RST_IRQ_EN;
      ist_reg    <= '0;
      rdata_reg  <= '0;
    end else begin
      look_reg   <= look_next;
      pf_thr_reg <= pf_thr_next;
      pe_thr_reg <= pe_thr_next;
      ien_reg    <= ien_next;
      ist_reg    <= ist_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = |(ist_reg & ien_reg);

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_ovf_flag: assert property ((wr_en && full) |=> overflow) // R17
    else $error("overflow not flagged for write while full");

  chk_ovf_keep: assert property ((wr_en && full && !rd_en && !flush)
                                 |=> (wr_ptr_reg == $past(wr_ptr_reg))
                                     && (count_reg == $past(count_reg))) // R17
    else $error("refused write changed the queue");

  chk_udf_flag: assert property ((rd_en && !pop) |=> underflow && $stable(rd_ptr_reg)) // R17
    else $error("underflow not flagged or pointer moved");

  chk_ack_write: assert property ((wr_en && !full) |=> wr_ack && !overflow) // R12
    else $error("accepted write not acknowledged");

  chk_look_show: assert property ((look_reg && count_reg >= RDU_C && !pop && !flush
                                   && !reg_wr) |=> rd_valid && !empty) // R01
    else $error("look-ahead word not shown");

  chk_std_lat: assert property ((!look_reg && pop && !flush && !reg_wr)
                                |-> ##PIPE_LAT rd_valid) // R04
    else $error("read valid latency wrong");

  chk_count_up: assert property ((push && !pop && !flush)
                                 |=> count_reg == $past(count_reg) + WRU_C) // R13
    else $error("count did not grow by one write word");

  chk_macro_flags: assert property (IS_MACRO |-> !almost_full && !almost_empty
                                    && (prog_full == macro_near_full)) // R10
    else $error("macro variant shows almost flags");

  chk_pfull_thr: assert property ((!IS_MACRO && push && !pop && !flush
                                   && 16'(count_reg + WRU_C) >= pf_thr_reg
                                   && !reg_wr) |=> prog_full) // R09
    else $error("programmable full missed threshold");

  chk_irq_set: assert property ((overflow && ien_reg[`FCQ_EV_OVF]
                                 && !(reg_wr && reg_addr == `FCQ_OFS_IRQ_EN)) |=> irq) // R12
    else $error("overflow event did not raise interrupt");

endmodule

// ==== fcq_consts.svh ====
// constants of the configurable native queue: register map, field positions, resets
// assumes a 32-bit plain register port and one 250 MHz clock
//
// Functional notes
// R01: look-ahead mode shows the oldest word on read data without any read request.
// R02: write and read widths may differ, ratio one-to-eight up to eight-to-one.
// R03: differing widths only for block RAM storage with separate clocks configured.
// R04: output pipeline register delays read data and read valid by one cycle.
// R05: shared-clock macro variant resets the output register to a configured value.
// R06: output pipeline register exists only for block RAM and shared-clock macro.
// R07: error injection and single-error correction for block RAM and macro storage.
// R08: RAM and shift register variants give full, almost-full, empty, almost-empty.
// R09: programmable full and empty assert against user defined thresholds.
// R10: macro variants give only full and empty, no almost flags.
// R11: macro variants drive programmable flags from macro near-full and near-empty.
// R12: optional write acknowledge, overflow, read valid and underflow outputs.
// R13: shared clock: a count output reports the words currently held.
// R14: separate clocks: write and read side counts, each in its own domain; the code derives both from one count_reg on clk.
// R15: read operations follow the read clock, write operations the write clock; the code runs both on the single clk.
// R16: shared-clock block and distributed RAM may use synchronous or asynchronous reset.
// R17: overflow on write while full, underflow on read while empty, contents unchanged.
// R18: words leave in exactly the order they were accepted.
`ifndef FCQ_CONSTS_SVH
`define FCQ_CONSTS_SVH

// ==========================================
// register offsets
`define FCQ_OFS_CTRL        8'h00
`define FCQ_OFS_PFULL_THR   8'h04
`define FCQ_OFS_PEMPTY_THR  8'h08
`define FCQ_OFS_STATUS      8'h0C
`define FCQ_OFS_COUNT       8'h10
`define FCQ_OFS_IRQ_STAT    8'h14
`define FCQ_OFS_IRQ_EN      8'h18
`define FCQ_OFS_IRQ_CLR     8'h1C

// ==========================================
// field positions
`define FCQ_CTRL_LOOK       0
`define FCQ_CTRL_FLUSH      1
`define FCQ_ST_FULL         0
`define FCQ_ST_EMPTY        1
`define FCQ_ST_AFULL        2
`define FCQ_ST_AEMPTY       3
`define FCQ_ST_PFULL        4
`define FCQ_ST_PEMPTY       5
`define FCQ_EV_OVF          0
`define FCQ_EV_UDF          1
`define FCQ_EV_SBIT         2
`define FCQ_EV_DBIT         3
`define FCQ_EV_W            4

// ==========================================
// reset values
`define FCQ_RST_CTRL        1'b0
`define FCQ_RST_PFULL_THR   16'h01F0
`define FCQ_RST_PEMPTY_THR  16'h0010
`define FCQ_RST_IRQ_EN      4'h0

// ==========================================
// timing
`define FCQ_CLK_PERIOD_NS   4
`define FCQ_PIPE_CYCLES     1

`endif

// ==== fcq_pkg.sv ====
// types shared by the configurable native queue
// assumes the constants header is compiled alongside
package fcq_pkg;
  typedef enum logic [1:0] {
    FCQ_MEM_BRAM,
    FCQ_MEM_DRAM,
    FCQ_MEM_SHREG,
    FCQ_MEM_MACRO
  } fcq_mem_e;
endpackage

// ==== fcq_user_model.sv ====
// user read-side logic for the native queue: pops words when told to drain
// assumes one clock shared with the queue; outputs change just after rising edges
module fcq_user_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        drain,
  input  wire logic        fast,
  input  wire logic        force_rd,
  input  wire logic        empty,
  input  wire logic [15:0] data_count,
  output logic             rd_en
);
  timeunit 1ns;
  timeprecision 100ps;

  logic auto_reg;
  logic auto_next;

  // ==========================================
  // read pacing
  // slow mode leaves a gap, so a stale empty flag never causes a read of nothing
  always_comb begin
    auto_next = drain && !empty && (!auto_reg || (fast && data_count > 16'h0001));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_reg <= 1'b0;
    end else begin
      auto_reg <= auto_next;
    end
  end

  // forced read ignores the flags, used only to provoke a refusal or a look-ahead pop
  assign rd_en = auto_reg || force_rd;
endmodule

// ==== tb_top.sv ====
// self-checking bench for the native queue: registers, flags, handshake, order, interrupt
// assumes the common-clock block RAM form with a reduced depth
`include "fcq_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DEPTH = 16;
  localparam logic [7:0]  ROW_ADDR [8] = '{`FCQ_OFS_CTRL, `FCQ_OFS_PFULL_THR,
    `FCQ_OFS_PEMPTY_THR, `FCQ_OFS_STATUS, `FCQ_OFS_COUNT, `FCQ_OFS_IRQ_STAT,
    `FCQ_OFS_IRQ_EN, 8'h20};
  localparam logic [31:0] ROW_EXP  [8] = '{32'h0, {16'h0, `FCQ_RST_PFULL_THR},
    {16'h0, `FCQ_RST_PEMPTY_THR}, 32'h2A, 32'h0, 32'h0, 32'h0, 32'h0};

  logic        clk;
  logic        rst_b;
  logic        wr_en;
  logic [7:0]  wr_data;
  wire logic   rd_en;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        full;
  logic        empty;
  logic        almost_full;
  logic        almost_empty;
  logic        prog_full;
  logic        prog_empty;
  logic        wr_ack;
  logic        overflow;
  logic        underflow;
  logic [15:0] data_count;
  logic [15:0] wr_count;
  logic [15:0] rd_count;
  logic        sbit_err;
  logic        dbit_err;
  logic        srst;
  logic        inj_sbit;
  logic        inj_dbit;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        drain;
  logic        fast;
  logic        force_rd;
  logic        mon_on;
  logic [7:0]  exp_q [$];
  int          num_errors;
  int          check_count;
  int          rd_seen;

  fcq_fifo #(.DEPTH(DEPTH), .ECC_EN(1'b1), .SYNC_RST(1'b1)) fcq_fifo_i (.clk(clk),
    .rst_b(rst_b), .srst(srst), .wr_en(wr_en), .wr_data(wr_data), .inj_sbit(inj_sbit),
    .inj_dbit(inj_dbit), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .sbit_err(sbit_err), .dbit_err(dbit_err), .full(full),
    .empty(empty), .almost_full(almost_full), .almost_empty(almost_empty),
    .prog_full(prog_full), .prog_empty(prog_empty), .wr_ack(wr_ack),
    .overflow(overflow), .underflow(underflow), .data_count(data_count),
    .wr_count(wr_count), .rd_count(rd_count), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  fcq_user_model fcq_user_model_i (.clk(clk), .rst_b(rst_b), .drain(drain), .fast(fast),
    .force_rd(force_rd), .empty(empty), .data_count(data_count), .rd_en(rd_en));

  // ==========================================
  // compare and bus tasks
  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_expect(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk_val(reg_rdata, exp);
  endtask

  task automatic push(input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic pulse_rd;
    @(posedge clk);
    force_rd <= 1'b1;
    @(posedge clk);
    force_rd <= 1'b0;
    @(negedge clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // clock, read monitor, watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // standard mode only: look-ahead shows words without a read pulse
  // sampled mid-cycle, away from the edge that launches the valid pulse
  always @(negedge clk) begin
    if (mon_on && rd_valid === 1'b1) begin
      chk_flag(sbit_err, rd_seen == 3);
      chk_flag(dbit_err, rd_seen == 5);
      rd_seen++;
      if (exp_q.size() == 0) begin
        chk_flag(1'b1, 1'b0);
      end else begin
        chk_val({24'h0, rd_data}, {24'h0, exp_q.pop_front()});
      end
    end
  end

  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop;
  end

  // ==========================================
  // main sequence
  initial begin
    int n;
    rst_b = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    drain = 1'b0;
    fast = 1'b0;
    force_rd = 1'b0;
    srst = 1'b0;
    inj_sbit = 1'b0;
    inj_dbit = 1'b0;
    rd_seen = 0;
    mon_on = 1'b0;
    num_errors = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      reg_expect(ROW_ADDR[r], ROW_EXP[r]);
    end
    reg_write(`FCQ_OFS_PFULL_THR, 32'hE);
    reg_write(`FCQ_OFS_PEMPTY_THR, 32'h2);
    reg_expect(`FCQ_OFS_PFULL_THR, 32'hE);
    // back-to-back fill past full with the reader stalled
    for (int i = 0; i <= DEPTH + 1; i++) begin
      @(posedge clk);
      wr_en <= (i <= DEPTH);
      wr_data <= 8'(i) ^ 8'h5A;
      inj_sbit <= (i == 3);
      inj_dbit <= (i == 5);
      // a double error leaves the word damaged in bit 0
      if (i < DEPTH) exp_q.push_back(8'(i) ^ 8'h5A ^ {7'h0, i == 5});
      @(negedge clk);
      n = (i < DEPTH) ? i : DEPTH;
      if (i > 0) begin
        chk_flag(wr_ack, i <= DEPTH);
        chk_flag(overflow, i == DEPTH + 1);
      end
      chk_val(32'(data_count), n);
      chk_val(32'(wr_count), n);
      chk_val(32'(rd_count), n);
      chk_flag(full, n == DEPTH);
      chk_flag(almost_full, n >= DEPTH - 1);
      chk_flag(almost_empty, n < 2);
      chk_flag(prog_full, n >= 14);
      chk_flag(prog_empty, n <= 2);
    end
    reg_expect(`FCQ_OFS_STATUS, 32'h15);
    reg_expect(`FCQ_OFS_IRQ_STAT, 32'h1);
    chk_flag(irq, 1'b0);
    reg_write(`FCQ_OFS_IRQ_EN, 32'h1);
    @(negedge clk);
    chk_flag(irq, 1'b1);
    reg_write(`FCQ_OFS_IRQ_CLR, 32'h1);
    @(negedge clk);
    chk_flag(irq, 1'b0);
    // drain slowly, then promptly; order checked by the monitor
    mon_on = 1'b1;
    @(posedge clk);
    drain <= 1'b1;
    repeat (12) @(posedge clk);
    fast <= 1'b1;
    for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge clk);
    drain <= 1'b0;
    repeat (2) @(negedge clk);
    chk_val(exp_q.size(), 0);
    chk_flag(empty, 1'b1);
    pulse_rd;
    chk_flag(underflow, 1'b1);
    chk_val(32'(data_count), 0);
    reg_expect(`FCQ_OFS_IRQ_STAT, 32'hE);
    chk_flag(irq, 1'b0);
    // look-ahead: shown without a read, popped by one read
    mon_on = 1'b0;
    reg_write(`FCQ_OFS_CTRL, 32'h1);
    push(8'h3C);
    push(8'hC3);
    repeat (3) @(negedge clk);
    chk_flag(rd_valid, 1'b1);
    chk_val({24'h0, rd_data}, 32'h3C);
    pulse_rd;
    chk_val({24'h0, rd_data}, 32'hC3);
    reg_write(`FCQ_OFS_CTRL, 32'h2);
    repeat (2) @(negedge clk);
    chk_flag(empty, 1'b1);
    reg_expect(`FCQ_OFS_CTRL, 32'h0);
    // synchronous clear drops the stored word
    push(8'h55);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk_flag(empty, 1'b1);
    chk_val(32'(data_count), 0);
    // asynchronous reset in mid-run clears contents and enables
    push(8'h77);
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    chk_flag(empty, 1'b1);
    chk_val(32'(data_count), 0);
    @(posedge clk);
    rst_b <= 1'b1;
    reg_expect(`FCQ_OFS_IRQ_EN, 32'h0);
    report_and_stop;
  end
endmodule
